//--- core/vp_pkg.sv
package vp_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ = 10_000_000;        // clk_sys rate
   localparam int SEC_PERIOD_S = 1;           // Base tick period, seconds
   localparam int SEC_CYCLES = CLK_HZ * SEC_PERIOD_S;
   localparam int DRAIN_TIME_S = 4;           // Valve open interval
   localparam int SETTLE_TIME_S = 3;          // Switch ignored interval
   localparam logic [11:0] DRAIN_SECS = 12'(DRAIN_TIME_S);
   localparam logic [11:0] SETTLE_SECS = 12'(SETTLE_TIME_S);

   // ****************************************************************
   // Test duration steps
   // ****************************************************************
   localparam logic [11:0] FINE_LIMIT = 12'h03c;     // 60 s
   localparam logic [11:0] MID_LIMIT = 12'h258;      // 600 s
   localparam logic [11:0] MAX_TIME = 12'he10;       // 3600 s
   localparam logic [11:0] MID_STEP = 12'h00a;       // 10 s
   localparam logic [11:0] COARSE_STEP = 12'h03c;    // 60 s

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ADDR_CONFIG = 5'h00;
   localparam logic [4:0] ADDR_TEST_TIME = 5'h04;
   localparam logic [4:0] ADDR_STATUS = 5'h08;
   localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
   localparam logic [11:0] TEST_TIME_RESET = 12'h000;

   // Event bits in status and mask registers
   localparam int EV_PASS = 0;
   localparam int EV_LOW_LEAK = 1;
   localparam int EV_HIGH_LEAK = 2;
   localparam int EV_ABORT = 3;
   localparam int EV_W = 4;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      SCHED_NEVER = 3'h0,
      SCHED_BEFORE = 3'h1,
      SCHED_AFTER = 3'h2,
      SCHED_BOTH = 3'h3,
      SCHED_SPLIT = 3'h4
   } sched_e;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DRAIN,
      ST_SETTLE_LOW,
      ST_CHECK_LOW,
      ST_FILL,
      ST_SETTLE_HIGH,
      ST_CHECK_HIGH,
      ST_LOCKOUT
   } prove_e;

   typedef struct packed {
      sched_e sched;
      logic [11:0] test_time;
   } cfg_s;

   typedef struct packed {
      logic switch_on;
      logic demand;
      logic busy;
      logic lockout;
      prove_e state;
   } stat_s;

endpackage : vp_pkg

//--- core/valve_prover.sv
`timescale 1ns/1ns
// Function
// - Five schedule choices selectable
// - Never by default, no proving then
// - Before: prove alongside pre-purge
// - After: prove after run, hold relay
// - Both: full test at both points
// - Split: high before, low after
// - Proving only while demand input asserted
// - Programmable switch monitoring duration
// - All intervals within ten percent
// - Drain: downstream open four seconds
// - Settle three seconds, switch ignored
// - Low check: switch on means lockout
// - Fill: upstream open four seconds
// - Settle three seconds again, switch ignored
// - High check: switch off means lockout
// - Duration steps 1s, 10s, 1min
module valve_prover
   import vp_pkg::*;
#(
   parameter int TICK_CYCLES = SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic prove_demand,
   input wire logic seat_pressure_switch,
   input wire logic prepurge_req,
   input wire logic postrun_req,
   output logic upstream_valve,
   output logic downstream_valve,
   output logic before_ok,
   output logic after_ok,
   output logic relay_hold,
   output logic lockout,
   output logic irq
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Snap a requested duration to the legal step grid
   function automatic logic [11:0] snap_time(input logic [11:0] t);
      logic [11:0] c;
      c = (t > MAX_TIME) ? MAX_TIME : t;
      if (c <= FINE_LIMIT) begin
         snap_time = c;
      end else if (c <= MID_LIMIT) begin
         snap_time = c - (c % MID_STEP);
      end else begin
         snap_time = c - (c % COARSE_STEP);
      end
   endfunction : snap_time

   // Two-flop synchroniser stage update
   function automatic logic [1:0] sync2(input logic [1:0] s,
                                        input logic d);
      sync2 = {s[0], d};
   endfunction : sync2

   // True while a proving step is running
   function automatic logic in_test(input prove_e s);
      in_test = s != ST_IDLE && s != ST_LOCKOUT;
   endfunction : in_test

   // Valve step ends on the tick that empties its last second
   function automatic logic valve_done(input logic t,
                                       input logic [11:0] left);
      valve_done = t && left == 12'h001;
   endfunction : valve_done

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] demand_sy;
   logic [1:0] switch_sy;
   logic [1:0] pre_sy;
   logic [1:0] post_sy;
   logic pre_d;
   logic post_d;

   // Two flops per pin before any logic
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         demand_sy <= 2'h0;
         switch_sy <= 2'h0;
         pre_sy <= 2'h0;
         post_sy <= 2'h0;
         pre_d <= 1'b0;
         post_d <= 1'b0;
      end else begin
         demand_sy <= sync2(demand_sy, prove_demand);
         switch_sy <= sync2(switch_sy, seat_pressure_switch);
         pre_sy <= sync2(pre_sy, prepurge_req);
         post_sy <= sync2(post_sy, postrun_req);
         pre_d <= pre_sy[1];
         post_d <= post_sy[1];
      end
   end

   // Synchronised levels and request edges
   wire demand = demand_sy[1];
   wire sw_on = switch_sy[1];
   wire pre_rise = pre_sy[1] && !pre_d;
   wire post_rise = post_sy[1] && !post_d;

   // ****************************************************************
   // Registers and bus slave
   // ****************************************************************
   cfg_s cfg;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_mask;
   logic [EV_W-1:0] ev;
   stat_s stat;
   prove_e state;

   // Bus decode, a request is taken while waitrequest is high
   wire access = (avs_read || avs_write) && avs_waitrequest;
   wire wr_go = avs_write && !avs_waitrequest;
   wire be0 = avs_byteenable[0];
   wire be1 = avs_byteenable[1];
   wire wr_cfg = wr_go && avs_address == ADDR_CONFIG && be0;
   wire wr_time = wr_go && avs_address == ADDR_TEST_TIME;
   wire wr_irqs = wr_go && avs_address == ADDR_IRQ_STATUS && be0;
   wire wr_mask = wr_go && avs_address == ADDR_IRQ_MASK && be0;
   wire [2:0] wr_sched = avs_writedata[2:0];
   wire sched_legal = wr_sched <= SCHED_SPLIT;
   wire [11:0] time_merge = {be1 ? avs_writedata[11:8]
                                 : cfg.test_time[11:8],
                             be0 ? avs_writedata[7:0]
                                 : cfg.test_time[7:0]};

   // Status word from live state and synchronised pins
   assign stat = '{switch_on: sw_on, demand: demand,
                   busy: in_test(state),
                   lockout: state == ST_LOCKOUT, state: state};

   // Read data selection
   logic [31:0] rd_mux;
   always_comb begin
      unique case (avs_address)
         ADDR_CONFIG: rd_mux = {29'h0, cfg.sched};
         ADDR_TEST_TIME: rd_mux = {20'h0, cfg.test_time};
         ADDR_STATUS: rd_mux = {24'h0, stat};
         ADDR_IRQ_STATUS: rd_mux = {28'h0, irq_status};
         ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask};
         default: rd_mux = 32'h0;
      endcase
   end

   // One wait state, answer on the following edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= !access;
         avs_readdata <= access ? rd_mux : 32'h0;
      end
   end

   // Configuration writes
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg.sched <= SCHED_NEVER;
         cfg.test_time <= TEST_TIME_RESET;
      end else begin
         if (wr_cfg && sched_legal) begin
            cfg.sched <= sched_e'(wr_sched);
         end
         if (wr_time) begin
            cfg.test_time <= snap_time(time_merge);
         end
      end
   end

   // Sticky events, set wins over write-one-clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status &
                        ~(wr_irqs ? avs_writedata[EV_W-1:0] : '0)) | ev;
         if (wr_mask) begin
            irq_mask <= avs_writedata[EV_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // ****************************************************************
   // Seconds timebase
   // ****************************************************************
   // Prescaler count and whole seconds left in the step
   logic [23:0] pre_cnt;
   logic [11:0] secs_left;
   logic enter;
   logic [11:0] load_secs;
   wire tick = pre_cnt == 24'(TICK_CYCLES - 1);
   wire expired = secs_left == 12'h000;

   // Prescaler restarts at each step so intervals are exact
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= 24'h0;
         secs_left <= 12'h000;
      end else if (enter) begin
         pre_cnt <= 24'h0;
         secs_left <= load_secs;
      end else begin
         pre_cnt <= tick ? 24'h0 : pre_cnt + 24'h1;
         if (tick && !expired) begin
            secs_left <= secs_left - 12'h001;
         end
      end
   end

   // ****************************************************************
   // Proving sequencer
   // ****************************************************************
   logic at_after;
   logic low_only;
   logic next_at_after;
   logic next_low_only;
   prove_e next_state;
   logic next_before_ok;
   logic next_after_ok;

   // Schedule decode, demand gates both points
   wire sched_pre = cfg.sched == SCHED_BEFORE || cfg.sched == SCHED_BOTH;
   wire sched_post = cfg.sched == SCHED_AFTER || cfg.sched == SCHED_BOTH;
   wire split = cfg.sched == SCHED_SPLIT;
   wire run_pre = demand && (sched_pre || split);
   wire run_post = demand && (sched_post || split);

   // Next state and step timing
   always_comb begin
      next_state = state;
      next_at_after = at_after;
      next_low_only = low_only;
      next_before_ok = before_ok && pre_sy[1];
      next_after_ok = after_ok && post_sy[1];
      enter = 1'b0;
      load_secs = 12'h000;
      ev = '0;
      unique case (state)
         ST_IDLE: begin
            if (pre_rise) begin
               if (run_pre) begin
                  next_at_after = 1'b0;
                  next_low_only = 1'b0;
                  next_state = split ? ST_FILL : ST_DRAIN;
                  enter = 1'b1;
                  load_secs = DRAIN_SECS;
               end else begin
                  next_before_ok = 1'b1;
               end
            end else if (post_rise) begin
               if (run_post) begin
                  next_at_after = 1'b1;
                  next_low_only = split;
                  next_state = ST_DRAIN;
                  enter = 1'b1;
                  load_secs = DRAIN_SECS;
               end else begin
                  next_after_ok = 1'b1;
               end
            end
         end
         ST_DRAIN: begin
            if (valve_done(tick, secs_left)) begin
               next_state = ST_SETTLE_LOW;
               enter = 1'b1;
               load_secs = SETTLE_SECS;
            end
         end
         ST_SETTLE_LOW: begin
            if (expired) begin
               next_state = ST_CHECK_LOW;
               enter = 1'b1;
               load_secs = cfg.test_time;
            end
         end
         ST_CHECK_LOW: begin
            if (sw_on) begin
               next_state = ST_LOCKOUT;
               ev[EV_LOW_LEAK] = 1'b1;
            end else if (expired) begin
               if (low_only) begin
                  next_state = ST_IDLE;
                  next_after_ok = 1'b1;
                  ev[EV_PASS] = 1'b1;
               end else begin
                  next_state = ST_FILL;
                  enter = 1'b1;
                  load_secs = DRAIN_SECS;
               end
            end
         end
         ST_FILL: begin
            if (valve_done(tick, secs_left)) begin
               next_state = ST_SETTLE_HIGH;
               enter = 1'b1;
               load_secs = SETTLE_SECS;
            end
         end
         ST_SETTLE_HIGH: begin
            if (expired) begin
               next_state = ST_CHECK_HIGH;
               enter = 1'b1;
               load_secs = cfg.test_time;
            end
         end
         ST_CHECK_HIGH: begin
            if (!sw_on) begin
               next_state = ST_LOCKOUT;
               ev[EV_HIGH_LEAK] = 1'b1;
            end else if (expired) begin
               next_state = ST_IDLE;
               next_before_ok = !at_after || before_ok;
               next_after_ok = at_after || after_ok;
               ev[EV_PASS] = 1'b1;
            end
         end
         ST_LOCKOUT: begin
            next_state = ST_LOCKOUT;
         end
      endcase
      // Demand withdrawn mid-test ends the test, valves closed
      if (!demand && in_test(state)) begin
         next_state = ST_IDLE;
         ev[EV_ABORT] = 1'b1;
      end
   end

   // Valve drive per state
   wire next_down = next_state == ST_DRAIN;
   wire next_up = next_state == ST_FILL;
   wire next_hold = next_state != ST_IDLE && next_at_after;

   // State and output registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         at_after <= 1'b0;
         low_only <= 1'b0;
         before_ok <= 1'b0;
         after_ok <= 1'b0;
         upstream_valve <= 1'b0;
         downstream_valve <= 1'b0;
         relay_hold <= 1'b0;
         lockout <= 1'b0;
      end else begin
         state <= next_state;
         at_after <= next_at_after;
         low_only <= next_low_only;
         before_ok <= next_before_ok;
         after_ok <= next_after_ok;
         upstream_valve <= next_up;
         downstream_valve <= next_down;
         relay_hold <= next_hold;
         lockout <= next_state == ST_LOCKOUT;
      end
   end

endmodule : valve_prover

//--- testbench/valve_prover_props.sv
`timescale 1ns/1ns
module valve_prover_props
   import vp_pkg::*;
#(
   parameter int TICK_CYCLES = SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic prove_demand,
   input wire logic postrun_req,
   input wire logic upstream_valve,
   input wire logic downstream_valve,
   input wire logic relay_hold,
   input wire logic lockout
);
   // ********
   // Helper counters
   // ********
   logic [15:0] up_cnt;
   logic [15:0] dn_cnt;
   logic [15:0] quiet;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Open time of each valve, closed time since last close
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         up_cnt <= 16'h0000;
         dn_cnt <= 16'h0000;
         quiet <= 16'h0000;
      end else begin
         up_cnt <= upstream_valve ? up_cnt + 16'h0001 : 16'h0000;
         dn_cnt <= downstream_valve ? dn_cnt + 16'h0001 : 16'h0000;
         quiet <= (upstream_valve || downstream_valve) ? 16'h0000 :
            (quiet == 16'hffff) ? quiet : quiet + 16'h0001;
      end
   end

   // ********
   // Sequences and properties
   // ********
   sequence s_open;
      $rose(upstream_valve) || $rose(downstream_valve);
   endsequence
   sequence s_lock_start;
      $rose(lockout);
   endsequence

   chk_valves_apart: assert property (
      !(upstream_valve && downstream_valve)) else $error("Both valves open");
   chk_drain_time: assert property (
      $fell(downstream_valve) |-> dn_cnt == 16'(DRAIN_TIME_S * TICK_CYCLES))
      else $error("Drain length wrong");
   chk_fill_time: assert property (
      $fell(upstream_valve) |-> up_cnt == 16'(DRAIN_TIME_S * TICK_CYCLES))
      else $error("Fill length wrong");
   chk_settle_quiet: assert property (
      s_lock_start |-> quiet >= 16'(SETTLE_TIME_S * TICK_CYCLES))
      else $error("Lockout inside settle delay");
   chk_lock_valves: assert property (
      lockout |-> !upstream_valve && !downstream_valve)
      else $error("Valve open in lockout");
   chk_lock_held: assert property (
      lockout |=> lockout) else $error("Lockout left without reset");
   chk_demand_gate: assert property (
      s_open |-> $past(prove_demand, 3))
      else $error("Valve opened without demand");
   chk_relay_post: assert property (
      relay_hold |-> postrun_req)
      else $error("Relay held outside after point");
endmodule : valve_prover_props

bind valve_prover valve_prover_props #(.TICK_CYCLES(TICK_CYCLES))
   valve_prover_props_i (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .prove_demand(prove_demand),
   .postrun_req(postrun_req),
   .upstream_valve(upstream_valve),
   .downstream_valve(downstream_valve),
   .relay_hold(relay_hold),
   .lockout(lockout)
);

//--- testbench/valve_model.sv
`timescale 1ns/1ns
module valve_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic upstream_valve,
   input wire logic downstream_valve,
   input wire logic leak_up,
   input wire logic leak_down,
   output logic seat_pressure_switch
);
   // ********
   // Pressure between the seats
   // ********
   // Venting wins, then filling, then a seat leak while both closed
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) seat_pressure_switch <= 1'b0;
      else if (downstream_valve) seat_pressure_switch <= 1'b0;
      else if (upstream_valve) seat_pressure_switch <= 1'b1;
      else if (leak_up) seat_pressure_switch <= 1'b1;
      else if (leak_down) seat_pressure_switch <= 1'b0;
   end
endmodule : valve_model

//--- testbench/gas_valve_proving_sequencer_bench.sv
`timescale 1ns/1ns
module gas_valve_proving_sequencer_bench
   import vp_pkg::*;
();
   localparam int T = 20;
   // Settle plus a two-second check, within ten percent
   localparam int WIN_LO = (SETTLE_TIME_S + 2) * T * 9 / 10;
   localparam int WIN_HI = (SETTLE_TIME_S + 2) * T * 11 / 10;
   logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic prove_demand, seat_pressure_switch, prepurge_req, postrun_req;
   logic upstream_valve, downstream_valve, before_ok, after_ok;
   logic relay_hold, lockout, irq, leak_up, leak_down, up_q, dn_q, hold_seen;
   logic [7:0] seq;
   int gap, cyc, n_errors, checks_done, s, i;
   logic [11:0] tt_in [5] = '{12'h03d, 12'h257, 12'he0f, 12'hfa0, 12'h03b};
   logic [11:0] tt_ex [5] = '{12'h03c, 12'h24e, 12'hdd4, 12'he10, 12'h03b};
   logic [7:0] pre_ex [5] = '{8'h00, 8'h06, 8'h00, 8'h06, 8'h02};
   logic [7:0] post_ex [5] = '{8'h00, 8'h00, 8'h06, 8'h06, 8'h01};

   valve_prover #(.TICK_CYCLES(T)) valve_prover_i (.clk_sys(clk_sys),
      .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .prove_demand(prove_demand),
      .seat_pressure_switch(seat_pressure_switch),
      .prepurge_req(prepurge_req), .postrun_req(postrun_req),
      .upstream_valve(upstream_valve), .downstream_valve(downstream_valve),
      .before_ok(before_ok), .after_ok(after_ok), .relay_hold(relay_hold),
      .lockout(lockout), .irq(irq));
   valve_model valve_model_i (.clk_sys(clk_sys), .nrst(nrst),
      .upstream_valve(upstream_valve), .downstream_valve(downstream_valve),
      .leak_up(leak_up), .leak_down(leak_down),
      .seat_pressure_switch(seat_pressure_switch));

   // ********
   // Clock, monitors and tasks
   // ********
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Valve opening order, relay hold, time since fill, watchdog
   always @(posedge clk_sys) begin
      up_q <= upstream_valve;
      dn_q <= downstream_valve;
      if (downstream_valve && !dn_q) seq <= {seq[5:0], 2'h1};
      if (upstream_valve && !up_q) seq <= {seq[5:0], 2'h2};
      if (relay_hold) hold_seen <= 1'b1;
      gap <= upstream_valve ? 0 : gap + 1;
      cyc <= cyc + 1;
      if (cyc > 40000) begin
         n_errors++;
         wrap_up();
      end
   end

   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One Avalon transfer, held until waitrequest is sampled low
   task bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
      avs_address <= a;
      avs_write <= is_wr;
      avs_read <= !is_wr;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task rd(input string w, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(w, q, exp);
   endtask : rd

   // Fire one trigger point and wait for its outcome
   task point(input logic pre, input logic [7:0] exp_seq, input logic exp_lk);
      seq = 8'h00;
      hold_seen = 1'b0;
      if (pre) prepurge_req <= 1'b1;
      else postrun_req <= 1'b1;
      repeat (3000) begin
         @(posedge clk_sys);
         if ((pre ? before_ok : after_ok) === 1'b1 || lockout === 1'b1) break;
      end
      chk("valve order", seq, exp_seq);
      chk("lockout", lockout, exp_lk);
      chk("done", pre ? before_ok : after_ok, !exp_lk);
      if (exp_seq[1:0] == 2'h2 && !exp_lk)
         chk("check time", gap >= WIN_LO && gap <= WIN_HI, 1);
      prepurge_req <= 1'b0;
      postrun_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : point

   task restart;
      nrst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      wr(ADDR_CONFIG, 32'h1);
      wr(ADDR_TEST_TIME, 32'h2);
      wr(ADDR_IRQ_MASK, 32'hf);
   endtask : restart

   // ********
   // Main sequence
   // ********
   initial begin
      {nrst, avs_read, avs_write, prepurge_req, postrun_req} = 5'h00;
      {leak_up, leak_down, up_q, dn_q, hold_seen} = 5'h00;
      {avs_address, avs_writedata, seq} = 45'h0;
      {gap, cyc, n_errors, checks_done} = 128'h0;
      avs_byteenable = 4'hf;
      prove_demand = 1'b1;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd("config reset", ADDR_CONFIG, 32'h0);
      rd("unmapped", 5'h14, 32'h0);
      for (i = 0; i < 5; i++) begin
         wr(ADDR_TEST_TIME, 32'(tt_in[i]));
         rd("test time", ADDR_TEST_TIME, 32'(tt_ex[i]));
      end
      wr(ADDR_TEST_TIME, 32'h2);
      wr(ADDR_IRQ_MASK, 32'hf);
      for (s = 0; s < 5; s++) begin
         wr(ADDR_CONFIG, 32'(s));
         point(1'b1, pre_ex[s], 1'b0);
         point(1'b0, post_ex[s], 1'b0);
         chk("relay hold", hold_seen, post_ex[s] != 8'h00);
      end
      chk("pass irq", irq, 1);
      rd("pass event", ADDR_IRQ_STATUS, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk("irq cleared", irq, 0);
      wr(ADDR_CONFIG, 32'h1);
      wr(ADDR_CONFIG, 32'h5);
      rd("bad schedule", ADDR_CONFIG, 32'h1);
      prepurge_req <= 1'b1;
      repeat (3000) begin
         @(posedge clk_sys);
         if (downstream_valve === 1'b1) break;
      end
      repeat (8 * T) @(posedge clk_sys);
      prove_demand <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd("abort event", ADDR_IRQ_STATUS, 32'h8);
      chk("abort", {upstream_valve, downstream_valve, lockout}, 0);
      prepurge_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      point(1'b1, 8'h00, 1'b0);
      prove_demand <= 1'b1;
      wr(ADDR_IRQ_STATUS, 32'hf);
      leak_up <= 1'b1;
      point(1'b1, 8'h01, 1'b1);
      rd("low leak", ADDR_IRQ_STATUS, 32'h2);
      repeat (100) @(posedge clk_sys);
      chk("held valves", {upstream_valve, downstream_valve}, 0);
      chk("held lock", {lockout, irq}, 2'h3);
      rd("lock status", ADDR_STATUS, 32'hd7);
      restart();
      leak_up <= 1'b0;
      leak_down <= 1'b1;
      point(1'b1, 8'h06, 1'b1);
      rd("high leak", ADDR_IRQ_STATUS, 32'h4);
      wr(ADDR_IRQ_MASK, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk("irq masked", irq, 0);
      wrap_up();
   end
endmodule : gas_valve_proving_sequencer_bench
